// [qmec_pkg.sv]
package qmec_pkg;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam logic [7:0] CMD_READ_SR1 = 8'h05;
    localparam logic [7:0] CMD_READ_SR2 = 8'h35;
    localparam logic [7:0] CMD_WRITE_SR = 8'h01;
    localparam logic [7:0] CMD_QUAD_ON = 8'h38;
    localparam logic [7:0] CMD_QUAD_OFF = 8'hF5;
    localparam logic [7:0] CMD_QUAD_READ = 8'hEB;
    localparam logic [7:0] MODE_ENTER = 8'hA5;
    localparam logic [7:0] MODE_EXIT = 8'h00;
    localparam logic [7:0] MODE_ALL_ONES = 8'hFF;
    localparam int QE_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam int PARAM_CONT_BIT = 9;
    localparam int PARAM_HOLD_BIT = 23;
    localparam int PARAM_TOP_LSB = 24;
    localparam logic [7:0] PARAM_TOP = 8'hFF;
    localparam logic [31:0] PARAM_WORD = 32'hFF5DF622;
    localparam logic [REG_AW-1:0] ADDR_PARAM = 8'h38;
    localparam logic [REG_AW-1:0] ADDR_STATUS = 8'h00;
    localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
    localparam logic [2:0] DUMMY_LAST = 3'h3;
    localparam logic [3:0] QUAD_OE = 4'hF;
    localparam logic [3:0] SERIAL_OE = 4'h2;
    localparam int STAT_QPI = 2;
    localparam int STAT_CONT = 3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CMD = 4'b0001,
        ST_WR1 = 4'b0010,
        ST_WR2 = 4'b0011,
        ST_ADDR = 4'b0100,
        ST_MODE = 4'b0101,
        ST_DUMMY = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_STAT = 4'b1000,
        ST_SKIP = 4'b1001
    } qmec_state_t;
endpackage

// [qmec_shift_if.sv]
`timescale 1ns/1ps
interface qmec_shift_if;
    logic sample;
    logic quad;
    logic clear;
    logic [3:0] din;
    logic [7:0] byte_q;
    logic byte_done;
    modport ctrl (output sample, output quad, output clear, output din,
                  input byte_q, input byte_done);
    modport shf (input sample, input quad, input clear, input din,
                 output byte_q, output byte_done);
endinterface // qmec_shift_if

// [qmec_sync.sv]
`timescale 1ns/1ps
module qmec_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // qmec_sync

// [qmec_shift.sv]
`timescale 1ns/1ps
module qmec_shift (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    qmec_shift_if.shf sh
);
    logic [2:0] cnt_q;
    logic [7:0] acc_q;
    wire [7:0] acc_d = sh.quad ? {acc_q[3:0], sh.din} : {acc_q[6:0], sh.din[0]};
    wire [2:0] cnt_d = sh.quad ? cnt_q + 3'h4 : cnt_q + 3'h1;
    wire full = sh.quad ? cnt_q[2] : (cnt_q == 3'h7);
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q <= '0;
            acc_q <= '0;
            sh.byte_q <= '0;
            sh.byte_done <= 1'b0;
        end else if (ce) begin
            sh.byte_done <= 1'b0;
            if (sh.clear) begin
                cnt_q <= '0;
            end else if (sh.sample) begin
                acc_q <= acc_d;
                cnt_q <= cnt_d;
                if (full) begin
                    sh.byte_q <= acc_d;
                    sh.byte_done <= 1'b1;
                end
            end
        end
    end
endmodule // qmec_shift

// [qmec_top.sv]
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module qmec_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] dq_i,
    output logic [3:0] dq_o,
    output logic [3:0] dq_oe,
    input wire logic [qmec_pkg::REG_AW-1:0] reg_addr,
    input wire logic [qmec_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [qmec_pkg::REG_DW-1:0] reg_rdata,
    output logic quad_enable_bit,
    output logic quad_cmd_mode,
    output logic cont_read_mode
);
    import qmec_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [5:0] pins_s;
    qmec_sync #(.W(6)) u_sync (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .d({sck, ~cs_n, dq_i}),
        .q(pins_s)
    );
    wire sck_s = pins_s[5];
    // select synced inverted so the flops reset to the idle (deselected) level
    wire cs_s = ~pins_s[4];
    wire [3:0] dq_s = pins_s[3:0];

    qmec_shift_if sh ();
    qmec_shift u_shift (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .sh(sh)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state
    qmec_state_t state_q, state_d;
    logic sck_q, cs_q;
    logic operation_in_progress_flag;
    logic qe_q, qpi_q, cont_q;
    logic qe_d, qpi_d, cont_d;
    logic [7:0] mode_q, mode_d;
    logic [7:0] out_q, addr_lo_q;
    logic [1:0] addr_cnt_q;
    logic [2:0] dummy_q, out_cnt_q;
    logic all_f_q, sel_sr2_q, in_read_q;

    wire sck_rise = sck_s & ~sck_q;
    wire sck_fall = ~sck_s & sck_q;
    wire cs_rise = cs_s & ~cs_q;
    wire [7:0] sr1 = {7'h00, operation_in_progress_flag};
    wire [7:0] sr2 = {6'h00, qe_q, 1'b0};
    wire [7:0] cmd = sh.byte_q;
    wire got = sh.byte_done;
    wire receiving = (state_q == ST_CMD) || (state_q == ST_WR1) ||
        (state_q == ST_WR2) || (state_q == ST_ADDR) || (state_q == ST_MODE);
    wire reset_pattern = all_f_q && (cmd == MODE_ALL_ONES);
    wire [7:0] stat_fresh = sel_sr2_q ? sr2 : sr1;
    wire [7:0] stat_cur = (out_cnt_q == 3'h0) ? stat_fresh : out_q;

    assign sh.sample = sck_rise && !cs_s && receiving;
    assign sh.quad = qpi_q || (state_q == ST_ADDR) || (state_q == ST_MODE);
    assign sh.clear = cs_s;
    assign sh.din = dq_s;

    ////////////////////////////////////////////////////////////////////////////
    // command decoder
    always_comb begin
        state_d = state_q;
        qe_d = qe_q;
        qpi_d = qpi_q;
        cont_d = cont_q;
        mode_d = mode_q;
        if (cs_s) begin
            state_d = ST_IDLE;
            if (cs_rise && in_read_q) begin
                cont_d = (mode_q == MODE_ENTER);
            end
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_d = cont_q ? ST_ADDR : ST_CMD;
                end
                ST_CMD: begin
                    if (got) begin
                        state_d = ST_SKIP;
                        if (cmd == CMD_READ_SR1 || cmd == CMD_READ_SR2) begin
                            state_d = ST_STAT;
                        end else if (cmd == CMD_WRITE_SR) begin
                            state_d = ST_WR1;
                        end else if (cmd == CMD_QUAD_ON) begin
                            qpi_d = 1'b1;
                        end else if (cmd == CMD_QUAD_OFF) begin
                            qpi_d = 1'b0;
                        end else if (cmd == CMD_QUAD_READ && qe_q) begin
                            state_d = ST_ADDR;
                        end
                    end
                end
                ST_WR1: begin
                    if (got) begin
                        state_d = ST_WR2;
                    end
                end
                ST_WR2: begin
                    if (got) begin
                        qe_d = cmd[QE_BIT];
                        state_d = ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    if (got && addr_cnt_q == ADDR_BYTES_LAST) begin
                        state_d = ST_MODE;
                    end
                end
                ST_MODE: begin
                    if (got) begin
                        mode_d = cmd;
                        if (reset_pattern) begin
                            cont_d = 1'b0;
                            state_d = ST_SKIP;
                        end else begin
                            state_d = ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sck_rise && dummy_q == DUMMY_LAST) begin
                        state_d = ST_RDATA;
                    end
                end
                ST_RDATA, ST_STAT, ST_SKIP: begin
                    state_d = state_q;
                end
                default: begin
                    state_d = ST_SKIP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            qe_q <= 1'b0;
            qpi_q <= 1'b0;
            cont_q <= 1'b0;
            mode_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            sck_q <= sck_s;
            cs_q <= cs_s;
            qe_q <= qe_d;
            qpi_q <= qpi_d;
            cont_q <= cont_d;
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame bookkeeping
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_cnt_q <= '0;
            dummy_q <= '0;
            all_f_q <= 1'b1;
            in_read_q <= 1'b0;
            sel_sr2_q <= 1'b0;
            addr_lo_q <= '0;
        end else if (ce) begin
            if (cs_s) begin
                addr_cnt_q <= '0;
                dummy_q <= '0;
                all_f_q <= 1'b1;
                in_read_q <= 1'b0;
            end else begin
                if (state_q == ST_ADDR && got) begin
                    addr_cnt_q <= addr_cnt_q + 2'h1;
                    addr_lo_q <= cmd;
                    all_f_q <= all_f_q && (cmd == MODE_ALL_ONES);
                end
                if (state_q == ST_DUMMY && sck_rise) begin
                    dummy_q <= dummy_q + 3'h1;
                end
                if (state_q == ST_MODE && got && !reset_pattern) begin
                    in_read_q <= 1'b1;
                end
                if (state_q == ST_CMD && got) begin
                    sel_sr2_q <= (cmd == CMD_READ_SR2);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output pins, driven on falling link clock
    always_ff @(posedge clock) begin
        if (rst) begin
            dq_o <= '0;
            dq_oe <= '0;
            out_q <= '0;
            out_cnt_q <= '0;
        end else if (ce) begin
            if (cs_s) begin
                dq_oe <= '0;
                out_cnt_q <= '0;
            end else if (sck_fall && state_q == ST_STAT) begin
                if (qpi_q) begin
                    dq_o <= stat_cur[7:4];
                    dq_oe <= QUAD_OE;
                    out_q <= {stat_cur[3:0], stat_cur[7:4]};
                    out_cnt_q <= out_cnt_q + 3'h4;
                end else begin
                    dq_o <= {2'b00, stat_cur[7], 1'b0};
                    dq_oe <= SERIAL_OE;
                    out_q <= {stat_cur[6:0], stat_cur[7]};
                    out_cnt_q <= out_cnt_q + 3'h1;
                end
            end else if (sck_fall && state_q == ST_RDATA) begin
                dq_o <= out_cnt_q[2] ? addr_lo_q[3:0] : addr_lo_q[7:4];
                dq_oe <= QUAD_OE;
                out_cnt_q <= out_cnt_q + 3'h4;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port
    logic [REG_DW-1:0] rd_mux;
    wire hit_param = (reg_addr == ADDR_PARAM);
    wire hit_stat = (reg_addr == ADDR_STATUS);
    wire [REG_DW-1:0] stat_word = {28'h0000000, cont_q, qpi_q, qe_q, operation_in_progress_flag};
    assign rd_mux = hit_param ? PARAM_WORD : (hit_stat ? stat_word : '0);

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= '0;
            operation_in_progress_flag <= 1'b0;
            quad_enable_bit <= 1'b0;
            quad_cmd_mode <= 1'b0;
            cont_read_mode <= 1'b0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : '0;
            if (reg_wr && hit_stat) begin
                operation_in_progress_flag <= reg_wdata[BUSY_BIT];
            end
            quad_enable_bit <= qe_q;
            quad_cmd_mode <= qpi_q;
            cont_read_mode <= cont_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_wr2_byte;
        ce && state_q == ST_WR2 && got && !cs_s;
    endsequence
    property p_qe_set;
        s_wr2_byte and cmd[QE_BIT] |=> qe_q ##2 quad_enable_bit;
    endproperty
    a_qe_set: assert property (p_qe_set) else $error("qe not set");
    property p_qe_clr;
        s_wr2_byte and !cmd[QE_BIT] |=> !qe_q && state_q == ST_SKIP;
    endproperty
    a_qe_clr: assert property (p_qe_clr) else $error("qe not cleared");
    property p_read_needs_qe;
        ce && state_q == ST_CMD && got && cmd == CMD_QUAD_READ && !qe_q && !cs_s
            |=> state_q == ST_SKIP;
    endproperty
    a_read_needs_qe: assert property (p_read_needs_qe) else $error("read without qe");
    property p_sr_sel;
        ce && state_q == ST_CMD && got && !cs_s &&
            (cmd == CMD_READ_SR1 || cmd == CMD_READ_SR2)
            |=> state_q == ST_STAT && sel_sr2_q == $past(cmd == CMD_READ_SR2);
    endproperty
    a_sr_sel: assert property (p_sr_sel) else $error("status select wrong");
    property p_qpi_on;
        ce && state_q == ST_CMD && got && !cs_s && cmd == CMD_QUAD_ON
            |=> qpi_q ##2 quad_cmd_mode;
    endproperty
    a_qpi_on: assert property (p_qpi_on) else $error("quad mode not entered");
    property p_qpi_off;
        ce && state_q == ST_CMD && got && !cs_s && cmd == CMD_QUAD_OFF |=> !qpi_q;
    endproperty
    a_qpi_off: assert property (p_qpi_off) else $error("quad mode not left");
    property p_cont_end;
        ce && cs_rise && in_read_q |=> cont_q == ($past(mode_q) == MODE_ENTER);
    endproperty
    a_cont_end: assert property (p_cont_end) else $error("continuous mode wrong");
    property p_reset_pat;
        ce && state_q == ST_MODE && got && !cs_s && reset_pattern
            |=> !cont_q && state_q == ST_SKIP;
    endproperty
    a_reset_pat: assert property (p_reset_pat) else $error("reset pattern ignored");
    property p_cont_addr;
        ce && state_q == ST_IDLE && !cs_s && cont_q |=> state_q == ST_ADDR;
    endproperty
    a_cont_addr: assert property (p_cont_addr) else $error("no address-first");
    property p_param;
        ce && reg_rd && hit_param |=> reg_rdata[PARAM_CONT_BIT] &&
            !reg_rdata[PARAM_HOLD_BIT] && reg_rdata[31:PARAM_TOP_LSB] == PARAM_TOP;
    endproperty
    a_param: assert property (p_param) else $error("parameter word wrong");
    property p_busy;
        ce && reg_wr && hit_stat |=> sr1[BUSY_BIT] == $past(reg_wdata[BUSY_BIT]);
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag wrong");
endmodule // qmec_top

// [qmec_host_model.sv]
`timescale 1ns/1ps
module qmec_host_model (
    input wire logic clock,
    output logic sck,
    output logic cs_n,
    output logic [3:0] dq_i,
    input wire logic [3:0] dq_o,
    input wire logic [3:0] dq_oe,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    logic [3:0] h_out = 4'h0;
    logic [3:0] h_oe = 4'h0;
    logic [3:0] junk = 4'h5;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    // released lines toggle every cycle
    always @(posedge clock) begin
        junk <= ~junk;
    end
    assign dq_i = (dq_oe & dq_o) | (~dq_oe & h_oe & h_out) | (~dq_oe & ~h_oe & junk);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic half();
        repeat (6) @(posedge clock);
    endtask
    // one link clock, data set while sck low, sampled at the rise
    task automatic tick(input logic [3:0] o, input logic [3:0] e, output logic [3:0] i);
        h_out <= o;
        h_oe <= e;
        half();
        i = dq_i;
        sck <= 1'b1;
        half();
        sck <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] b, input logic q);
        logic [3:0] t;
        if (q) begin
            tick(b[7:4], 4'hF, t);
            tick(b[3:0], 4'hF, t);
        end else begin
            for (int k = 7; k >= 0; k--) begin
                tick({3'b000, b[k]}, 4'h1, t);
            end
        end
    endtask
    task automatic rd(input logic q);
        logic [3:0] t;
        logic [7:0] r;
        if (q) begin
            tick(4'h0, 4'h0, t);
            r[7:4] = t;
            tick(4'h0, 4'h0, t);
            r[3:0] = t;
        end else begin
            for (int k = 7; k >= 0; k--) begin
                tick(4'h0, 4'h0, t);
                r[k] = t[1];
            end
        end
        rx_byte <= r;
        rx_valid <= 1'b1;
        @(posedge clock);
        rx_valid <= 1'b0;
    endtask
    task automatic dummy(input int n);
        logic [3:0] t;
        repeat (n) tick(4'h0, 4'h0, t);
    endtask
    task automatic frame_on();
        cs_n <= 1'b0;
        half();
    endtask
    task automatic frame_off();
        half();
        cs_n <= 1'b1;
        h_oe <= 4'h0;
        repeat (8) @(posedge clock);
    endtask
endmodule // qmec_host_model

// [tb.sv]
`timescale 1ns/1ps
module tb;
    import qmec_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic sck, cs_n, rx_valid, rd_d;
    logic [3:0] dq_i, dq_o, dq_oe;
    logic [7:0] rx_byte, b;
    logic [REG_AW-1:0] reg_addr = 8'h00;
    logic [REG_DW-1:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [REG_DW-1:0] reg_rdata;
    logic quad_enable_bit, quad_cmd_mode, cont_read_mode;
    logic [2:0] flags;
    logic [23:0] a;
    logic [31:0] exp_reg[$];
    logic [7:0] exp_link[$];
    int errors = 0;
    int checked = 0;
    assign flags = {cont_read_mode, quad_cmd_mode, quad_enable_bit};
    qmec_top u_dut (.clock(clock), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe(dq_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .quad_enable_bit(quad_enable_bit), .quad_cmd_mode(quad_cmd_mode),
        .cont_read_mode(cont_read_mode));
    qmec_host_model u_host (.clock(clock), .sck(sck), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe), .rx_byte(rx_byte), .rx_valid(rx_valid));
    initial begin
        forever #2 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // results are matched against the oldest note
    always @(posedge clock) begin
        if (rd_d === 1'b1) chk_word("reg_rdata", exp_reg.pop_front(), reg_rdata);
        if (rx_valid === 1'b1) chk_byte("link byte", exp_link.pop_front(), rx_byte);
        rd_d <= reg_rd;
    end
    initial begin
        #300000;
        errors++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] ad, input logic [31:0] e);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        exp_reg.push_back(e);
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_flag(input int k, input logic v);
        int n;
        n = 0;
        while (flags[k] !== v && n < 40) begin
            @(posedge clock);
            n++;
        end
        chk_word("mode flag", {31'b0, v}, {31'b0, flags[k]});
        if (n == 40) complete_run();
    endtask
    task automatic stat(input logic [7:0] c, input logic q, input logic [7:0] e);
        u_host.frame_on();
        u_host.wr(c, q);
        exp_link.push_back(e);
        u_host.rd(q);
        u_host.frame_off();
    endtask
    task automatic wsr(input logic [7:0] b2);
        u_host.frame_on();
        u_host.wr(CMD_WRITE_SR, 1'b0);
        u_host.wr(8'($urandom), 1'b0);
        u_host.wr(b2, 1'b0);
        u_host.frame_off();
    endtask
    task automatic qread(input logic [23:0] ad, input logic [7:0] m, input logic cmd,
            input logic take);
        u_host.frame_on();
        if (cmd) u_host.wr(CMD_QUAD_READ, 1'b0);
        u_host.wr(ad[23:16], 1'b1);
        u_host.wr(ad[15:8], 1'b1);
        u_host.wr(ad[7:0], 1'b1);
        u_host.wr(m, 1'b1);
        u_host.dummy(4);
        if (take) begin
            exp_link.push_back(ad[7:0]);
            u_host.rd(1'b1);
        end
        u_host.frame_off();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        a = 24'($urandom(32'hC046));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        reg_read(ADDR_PARAM, 32'hFF5DF622);
        reg_write(ADDR_PARAM, $urandom);
        reg_read(ADDR_PARAM, 32'hFF5DF622);
        reg_read(8'h40 | 8'($urandom & 32'h3F), 32'h0);
        ce <= 1'b0;
        reg_write(ADDR_STATUS, 32'h1);
        ce <= 1'b1;
        reg_read(ADDR_STATUS, 32'h0);
        $display("test registers done");
        reg_write(ADDR_STATUS, 32'h1);
        stat(8'h05, 1'b0, 8'h01);
        reg_write(ADDR_STATUS, 32'h0);
        stat(8'h05, 1'b0, 8'h00);
        $display("test busy done");
        stat(8'h35, 1'b0, 8'h00);
        b = 8'($urandom);
        wsr(b | 8'h02);
        wait_flag(0, 1'b1);
        stat(8'h35, 1'b0, 8'h02);
        reg_read(ADDR_STATUS, 32'h2);
        $display("test quad enable done");
        a = 24'($urandom);
        qread(a, 8'hA5, 1'b1, 1'b1);
        wait_flag(2, 1'b1);
        a = 24'($urandom);
        qread(a, 8'h00, 1'b0, 1'b1);
        wait_flag(2, 1'b0);
        qread(a ^ 24'h5A5A5A, 8'hA5, 1'b1, 1'b1);
        wait_flag(2, 1'b1);
        reg_read(ADDR_STATUS, 32'hA);
        qread(24'hFFFFFF, 8'hFF, 1'b0, 1'b0);
        wait_flag(2, 1'b0);
        $display("test continuous read done");
        wsr(b & 8'hFD);
        wait_flag(0, 1'b0);
        stat(8'h35, 1'b0, 8'h00);
        qread(a, 8'hA5, 1'b1, 1'b0);
        wait_flag(2, 1'b0);
        $display("test quad disable done");
        u_host.frame_on();
        u_host.wr(CMD_QUAD_ON, 1'b0);
        u_host.frame_off();
        wait_flag(1, 1'b1);
        stat(8'h05, 1'b1, 8'h00);
        u_host.frame_on();
        u_host.wr(CMD_QUAD_OFF, 1'b1);
        u_host.frame_off();
        wait_flag(1, 1'b0);
        $display("test all quad done");
        repeat (10) @(posedge clock);
        complete_run();
    end
endmodule // tb
